// ===== hdl/flash_iap_pkg.sv
// Purpose: Shared constants for the flash programming sequencer
// Assumes: 20 MHz core clock, byte-wide software register writes
// Notes: Register select codes are local to the plain write port
package flash_iap_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int PROG_TIME_NS = 2200000;
    localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int READ_CYCLES = 3;
    localparam int UNLOCK_CYCLES = 256;

    // Register select codes on the software write port
    localparam logic [3:0] SEL_CTRL = 4'h0;
    localparam logic [3:0] SEL_ADDR_LOW = 4'h1;
    localparam logic [3:0] SEL_ADDR_HIGH = 4'h2;
    localparam logic [3:0] SEL_DATA_BASE = 4'h3;
    localparam logic [3:0] SEL_BUF_CLEAR = 4'hb;

    // Control byte layout, then the buffer clear register bit
    localparam int BIT_ENABLED = 7;
    localparam int MODE_MSB = 6;
    localparam int MODE_LSB = 4;
    localparam int BIT_UNLOCK = 3;
    localparam int BIT_GO = 2;
    localparam int BIT_READ_EN = 1;
    localparam int BIT_READ_GO = 0;
    localparam int BIT_BUF_CLEAR = 0;

    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // Operation mode codes
    localparam logic [2:0] MODE_WRITE = 3'h0;
    localparam logic [2:0] MODE_ERASE = 3'h1;
    localparam logic [2:0] MODE_READ = 3'h3;
    localparam logic [2:0] MODE_ENABLE = 3'h6;

    // Unlock pattern, data1..3 low then data1..3 high
    localparam logic [7:0] PAT_LOW1 = 8'h00;
    localparam logic [7:0] PAT_LOW2 = 8'h0d;
    localparam logic [7:0] PAT_LOW3 = 8'hc3;
    localparam logic [7:0] PAT_HIGH1 = 8'h04;
    localparam logic [7:0] PAT_HIGH2 = 8'h09;
    localparam logic [7:0] PAT_HIGH3 = 8'h40;

    // Geometry
    localparam int ADDR_W = 13;
    localparam int PAGE_WORDS = 32;
    localparam int UNIT_WORDS = 4;
    localparam logic [4:0] PAGE_LAST = 5'h1f;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ERASE,
        ST_PROG,
        ST_WAIT,
        ST_READ
    } op_state_e;

endpackage

// ===== hdl/flash_iap_erase_write_read.sv
// Purpose: Erase, write and read sequencer for on-chip program flash
// Assumes: Software writes arrive as one-cycle strobes on core_clk
// Notes: One flash word strobe per cycle; the array holds its own data
`timescale 1ns/100ps
`default_nettype none

module flash_iap_erase_write_read #(
    parameter bit page_variant = 1'b1,
    parameter bit wide_addr = 1'b1,
    parameter int prog_cycles = flash_iap_pkg::PROG_CYCLES,
    parameter int unlock_cycles = flash_iap_pkg::UNLOCK_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic reg_wr,
    input wire logic [3:0] reg_sel,
    input wire logic [7:0] reg_wdata,
    input wire logic [15:0] flash_rdata,
    output logic [7:0] ctrl_q,
    output logic [7:0] addr_low_q,
    output logic [4:0] addr_high_q,
    output logic [7:0] data0_low_q,
    output logic [7:0] data0_high_q,
    output logic [7:0] data1_low_q,
    output logic [7:0] data1_high_q,
    output logic [7:0] data2_low_q,
    output logic [7:0] data2_high_q,
    output logic [7:0] data3_low_q,
    output logic [7:0] data3_high_q,
    output logic buffer_clear_q,
    output logic cpu_stall_q,
    output logic flash_erase_q,
    output logic flash_prog_q,
    output logic flash_read_q,
    output logic [12:0] flash_addr_q,
    output logic [15:0] flash_wdata_q
);

    typedef struct packed {
        flash_iap_pkg::op_state_e st;
        logic program_enabled_flag;
        logic [2:0] op_mode_select;
        logic unlock_trigger;
        logic program_go;
        logic read_enable_bit;
        logic read_go;
        logic buffer_clear_go;
        logic [7:0] addr_low_reg;
        logic [4:0] addr_high_reg;
        logic [3:0][15:0] data;
        logic [31:0][15:0] wbuf;
        logic [4:0] bptr;
        logic [15:0] win_cnt;
        logic [5:0] seen;
        logic [15:0] cnt;
        logic [4:0] widx;
        logic stall;
        logic f_erase;
        logic f_prog;
        logic f_read;
        logic [12:0] f_addr;
        logic [15:0] f_wdata;
    } seq_s;

    seq_s q;
    seq_s d;
    logic [2:0] mode_new;
    logic rden_new;
    logic [12:0] full_addr;
    logic [12:0] erase_addr;
    logic [12:0] prog_addr;
    logic [15:0] prog_data;
    logic [4:0] last_idx;
    logic pattern_ok;

    ////////////////////////////////////////////////////////////////////////
    // Address shaping

    always_comb begin
        full_addr = {q.addr_high_reg, q.addr_low_reg};
        if (!wide_addr) begin
            full_addr[12] = 1'b0;
        end
        if (page_variant) begin
            erase_addr = {full_addr[12:5], 5'h00};
            prog_addr = {full_addr[12:5], q.widx};
            prog_data = q.wbuf[q.widx];
            last_idx = 5'(flash_iap_pkg::PAGE_WORDS - 1);
        end else begin
            erase_addr = {2'b00, full_addr[10:8], 8'h00};
            prog_addr = {2'b00, full_addr[10:2], q.widx[1:0]};
            prog_data = q.data[q.widx[1:0]];
            last_idx = 5'(flash_iap_pkg::UNIT_WORDS - 1);
        end
    end

    // Pattern held in data1..3 registers
    always_comb begin
        pattern_ok = (q.data[1][7:0] == flash_iap_pkg::PAT_LOW1) &&
            (q.data[2][7:0] == flash_iap_pkg::PAT_LOW2) &&
            (q.data[3][7:0] == flash_iap_pkg::PAT_LOW3) &&
            (q.data[1][15:8] == flash_iap_pkg::PAT_HIGH1) &&
            (q.data[2][15:8] == flash_iap_pkg::PAT_HIGH2) &&
            (q.data[3][15:8] == flash_iap_pkg::PAT_HIGH3);
    end

    always_comb begin
        mode_new = reg_wdata[flash_iap_pkg::MODE_MSB:flash_iap_pkg::MODE_LSB];
        rden_new = reg_wdata[flash_iap_pkg::BIT_READ_EN];
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        d = q;
        d.f_erase = 1'b0;
        d.f_prog = 1'b0;
        d.f_read = 1'b0;

        // Unlock window timer
        if (q.unlock_trigger) begin
            if (q.win_cnt <= 16'h0001) begin
                d.unlock_trigger = 1'b0;
                d.win_cnt = 16'h0000;
            end else begin
                d.win_cnt = q.win_cnt - 16'h0001;
            end
        end

        // Buffer clear finishes first; a new request this cycle wins
        if (q.buffer_clear_go) begin
            d.wbuf = '0;
            d.bptr = q.addr_low_reg[4:0];
            d.buffer_clear_go = 1'b0;
        end

        // Software writes; the CPU cannot write while stalled
        if (reg_wr && q.st == flash_iap_pkg::ST_IDLE) begin
            if (reg_sel == flash_iap_pkg::SEL_CTRL) begin
                // Only a zero reaches the enabled flag
                if (!reg_wdata[flash_iap_pkg::BIT_ENABLED]) begin
                    d.program_enabled_flag = 1'b0;
                end
                d.op_mode_select = mode_new;
                d.read_enable_bit = rden_new;
                if (reg_wdata[flash_iap_pkg::BIT_UNLOCK] &&
                    !q.unlock_trigger &&
                    mode_new == flash_iap_pkg::MODE_ENABLE) begin
                    d.unlock_trigger = 1'b1;
                    d.win_cnt = 16'(unlock_cycles);
                    d.seen = 6'h00;
                end
                if (reg_wdata[flash_iap_pkg::BIT_GO]) begin
                    if (q.program_enabled_flag &&
                        (mode_new == flash_iap_pkg::MODE_ERASE ||
                         mode_new == flash_iap_pkg::MODE_WRITE)) begin
                        d.program_go = 1'b1;
                        d.stall = 1'b1;
                        d.widx = 5'h00;
                        if (mode_new == flash_iap_pkg::MODE_ERASE) begin
                            d.st = flash_iap_pkg::ST_ERASE;
                        end else begin
                            d.st = flash_iap_pkg::ST_PROG;
                        end
                    end
                end else if (reg_wdata[flash_iap_pkg::BIT_READ_GO] &&
                    rden_new && mode_new == flash_iap_pkg::MODE_READ) begin
                    // No enabled-flag check on reads
                    d.read_go = 1'b1;
                    d.stall = 1'b1;
                    d.f_read = 1'b1;
                    d.f_addr = full_addr;
                    d.cnt = 16'(flash_iap_pkg::READ_CYCLES);
                    d.st = flash_iap_pkg::ST_READ;
                end
            end else if (reg_sel == flash_iap_pkg::SEL_ADDR_LOW) begin
                d.addr_low_reg = reg_wdata;
                d.bptr = reg_wdata[4:0];
            end else if (reg_sel == flash_iap_pkg::SEL_ADDR_HIGH) begin
                d.addr_high_reg = reg_wdata[4:0];
            end else if (reg_sel == flash_iap_pkg::SEL_BUF_CLEAR) begin
                if (page_variant &&
                    reg_wdata[flash_iap_pkg::BIT_BUF_CLEAR]) begin
                    d.buffer_clear_go = 1'b1;
                end
            end
            for (int i = 0; i < 4; i++) begin
                if (reg_sel == 4'(flash_iap_pkg::SEL_DATA_BASE + 2 * i)) begin
                    d.data[i][7:0] = reg_wdata;
                    if (q.unlock_trigger && i > 0) begin
                        d.seen[i - 1] = 1'b1;
                    end
                end
                if (reg_sel ==
                    4'(flash_iap_pkg::SEL_DATA_BASE + 2 * i + 1)) begin
                    d.data[i][15:8] = reg_wdata;
                    if (q.unlock_trigger && i > 0) begin
                        d.seen[i + 2] = 1'b1;
                    end
                    if (page_variant && i == 0) begin
                        d.wbuf[q.bptr] = {reg_wdata, q.data[0][7:0]};
                        if (q.bptr != flash_iap_pkg::PAGE_LAST) begin
                            d.bptr = q.bptr + 5'h01;
                        end
                    end
                end
            end
        end

        // Full pattern inside the window; set wins over a clear
        if (q.unlock_trigger && (&q.seen) && pattern_ok) begin
            d.program_enabled_flag = 1'b1;
            // One-shot, so a later software clear in the window sticks
            d.seen = 6'h00;
        end

        unique case (q.st)
            flash_iap_pkg::ST_IDLE: begin
            end
            flash_iap_pkg::ST_ERASE: begin
                d.f_erase = 1'b1;
                d.f_addr = erase_addr;
                d.cnt = 16'(prog_cycles);
                d.st = flash_iap_pkg::ST_WAIT;
            end
            flash_iap_pkg::ST_PROG: begin
                d.f_prog = 1'b1;
                d.f_addr = prog_addr;
                d.f_wdata = prog_data;
                if (q.widx == last_idx) begin
                    d.cnt = 16'(prog_cycles);
                    d.st = flash_iap_pkg::ST_WAIT;
                end else begin
                    d.widx = q.widx + 5'h01;
                end
            end
            flash_iap_pkg::ST_WAIT: begin
                if (q.cnt <= 16'h0001) begin
                    d.program_go = 1'b0;
                    d.stall = 1'b0;
                    d.st = flash_iap_pkg::ST_IDLE;
                end else begin
                    d.cnt = q.cnt - 16'h0001;
                end
            end
            flash_iap_pkg::ST_READ: begin
                if (q.cnt <= 16'h0001) begin
                    d.data[0] = flash_rdata;
                    d.read_go = 1'b0;
                    d.stall = 1'b0;
                    d.st = flash_iap_pkg::ST_IDLE;
                end else begin
                    d.cnt = q.cnt - 16'h0001;
                end
            end
            default: begin
                d.st = flash_iap_pkg::ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign ctrl_q = {q.program_enabled_flag, q.op_mode_select,
        q.unlock_trigger, q.program_go, q.read_enable_bit, q.read_go};
    assign addr_low_q = q.addr_low_reg;
    assign addr_high_q = q.addr_high_reg;
    assign data0_low_q = q.data[0][7:0];
    assign data0_high_q = q.data[0][15:8];
    assign data1_low_q = q.data[1][7:0];
    assign data1_high_q = q.data[1][15:8];
    assign data2_low_q = q.data[2][7:0];
    assign data2_high_q = q.data[2][15:8];
    assign data3_low_q = q.data[3][7:0];
    assign data3_high_q = q.data[3][15:8];
    assign buffer_clear_q = q.buffer_clear_go;
    assign cpu_stall_q = q.stall;
    assign flash_erase_q = q.f_erase;
    assign flash_prog_q = q.f_prog;
    assign flash_read_q = q.f_read;
    assign flash_addr_q = q.f_addr;
    assign flash_wdata_q = q.f_wdata;

endmodule

`default_nettype wire

// ===== tb/flash_iap_checker.sv
// Purpose: Port checker for the flash programming sequencer
// Assumes: Page variant, single core_clk domain
// Notes: Bound from the testbench top file
`timescale 1ns/100ps
`default_nettype none
module flash_iap_checker #(
    parameter int unlock_cycles = flash_iap_pkg::UNLOCK_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic reg_wr,
    input wire logic [3:0] reg_sel,
    input wire logic [7:0] reg_wdata,
    input wire logic [15:0] flash_rdata,
    input wire logic [7:0] ctrl_q,
    input wire logic [7:0] data0_low_q,
    input wire logic [7:0] data0_high_q,
    input wire logic buffer_clear_q,
    input wire logic cpu_stall_q,
    input wire logic flash_erase_q,
    input wire logic flash_prog_q,
    input wire logic flash_read_q,
    input wire logic [12:0] flash_addr_q
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    logic ctl_wr;
    int trig_cnt_q;
    assign ctl_wr = reg_wr && reg_sel == 4'h0 && !cpu_stall_q;
    // Length of the unlock window as seen on the trigger bit
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            trig_cnt_q <= 0;
        end else if (ctrl_q[3]) begin
            trig_cnt_q <= trig_cnt_q + 1;
        end else begin
            trig_cnt_q <= 0;
        end
    end
    ////////////////////////////////////////////////////////////////////
    property p_trig_start;
        ctl_wr && reg_wdata[6:3] == 4'hd && !ctrl_q[3] |=> ctrl_q[3];
    endproperty
    a_trig_start: assert property (p_trig_start)
        else $error("Unlock trigger did not start");
    property p_trig_len;
        $fell(ctrl_q[3]) |-> trig_cnt_q == unlock_cycles;
    endproperty
    a_trig_len: assert property (p_trig_len)
        else $error("Unlock window length wrong");
    property p_sw_enable;
        ctl_wr && reg_wdata[7] && !ctrl_q[7] && !ctrl_q[3] |=> !ctrl_q[7];
    endproperty
    a_sw_enable: assert property (p_sw_enable)
        else $error("Software set the enabled flag");
    property p_sw_clear;
        ctl_wr && !reg_wdata[7] && !ctrl_q[3] |=> !ctrl_q[7];
    endproperty
    a_sw_clear: assert property (p_sw_clear)
        else $error("Enabled flag not cleared");
    property p_go_refused;
        ctl_wr && reg_wdata[2] && !ctrl_q[7] |=> !ctrl_q[2];
    endproperty
    a_go_refused: assert property (p_go_refused)
        else $error("Go accepted while locked");
    property p_erase;
        $rose(ctrl_q[2]) && ctrl_q[6:4] == 3'h1 |=>
            flash_erase_q && flash_addr_q[4:0] == 5'h00 && !flash_prog_q;
    endproperty
    a_erase: assert property (p_erase)
        else $error("Erase strobe missing");
    property p_prog;
        $rose(ctrl_q[2]) && ctrl_q[6:4] == 3'h0 |=>
            flash_prog_q && flash_addr_q[4:0] == 5'h00 ##1 flash_prog_q[*8];
    endproperty
    a_prog: assert property (p_prog)
        else $error("Program burst wrong");
    property p_read_time;
        $rose(ctrl_q[0]) |-> flash_read_q && cpu_stall_q ##1 ctrl_q[0][*2]
            ##1 !ctrl_q[0] && !cpu_stall_q;
    endproperty
    a_read_time: assert property (p_read_time)
        else $error("Read timing wrong");
    property p_read_data;
        $fell(ctrl_q[0]) |->
            {data0_high_q, data0_low_q} == $past(flash_rdata);
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("Read data not loaded");
    property p_buf_clear;
        reg_wr && reg_sel == 4'hb && reg_wdata[0] && !cpu_stall_q |=>
            buffer_clear_q ##1 !buffer_clear_q;
    endproperty
    a_buf_clear: assert property (p_buf_clear)
        else $error("Buffer clear bit wrong");
    c_erase: cover property ($rose(flash_erase_q));
    c_read: cover property ($fell(ctrl_q[0]));
    c_prog: cover property (ctrl_q[7] && flash_prog_q);
endmodule
`default_nettype wire

// ===== tb/flash_iap_erase_write_read_tb.sv
// Purpose: Self-checking bench for the flash programming sequencer
// Assumes: Page variant, shortened program and unlock counts
// Notes: Inputs change on the falling edge
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module flash_iap_erase_write_read_tb;
    localparam int PCYC = 20;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic reg_wr = 1'b0;
    logic [3:0] reg_sel = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [15:0] flash_rdata = 16'h0000;
    logic [7:0] ctrl_q, data0_low_q, data0_high_q;
    logic [7:0] addr_low_q, data1_low_q, data1_high_q, data2_low_q;
    logic [7:0] data2_high_q, data3_low_q, data3_high_q;
    logic [4:0] addr_high_q;
    logic buffer_clear_q, cpu_stall_q, flash_erase_q, flash_prog_q;
    logic flash_read_q;
    logic [12:0] flash_addr_q;
    logic [15:0] flash_wdata_q, w;
    logic [15:0] exp_w [32];
    // Rows: address, flash word; data0 must return the word
    logic [28:0] rows [3] = '{{13'h0000, 16'h1234},
        {13'h1fff, 16'hffff}, {13'h0a55, 16'h8001}};
    int errors = 0, checks = 0, cycles = 0, n, idx;
    flash_iap_erase_write_read #(.page_variant(1'b1), .wide_addr(1'b1),
        .prog_cycles(PCYC), .unlock_cycles(24)) flash_iap_erase_write_read_i (
        .core_clk(core_clk), .reset(reset), .reg_wr(reg_wr),
        .reg_sel(reg_sel), .reg_wdata(reg_wdata), .flash_rdata(flash_rdata),
        .ctrl_q(ctrl_q), .addr_low_q(addr_low_q),
        .addr_high_q(addr_high_q),
        .data0_low_q(data0_low_q), .data0_high_q(data0_high_q),
        .data1_low_q(data1_low_q), .data1_high_q(data1_high_q),
        .data2_low_q(data2_low_q), .data2_high_q(data2_high_q),
        .data3_low_q(data3_low_q), .data3_high_q(data3_high_q),
        .buffer_clear_q(buffer_clear_q),
        .cpu_stall_q(cpu_stall_q), .flash_erase_q(flash_erase_q),
        .flash_prog_q(flash_prog_q), .flash_read_q(flash_read_q),
        .flash_addr_q(flash_addr_q), .flash_wdata_q(flash_wdata_q));
    always #25 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("Checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] sel, input logic [7:0] dat);
        @(negedge core_clk);
        reg_wr = 1'b1;
        reg_sel = sel;
        reg_wdata = dat;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask
    // Six pattern bytes, third one spoiled by bad
    task automatic pat(input logic [7:0] bad);
        wr(4'h5, 8'h00);
        wr(4'h7, 8'h0d);
        wr(4'h9, 8'hc3 ^ bad);
        wr(4'h6, 8'h04);
        wr(4'h8, 8'h09);
        wr(4'ha, 8'h40);
    endtask
    task automatic wait_go();
        n = 0;
        while (ctrl_q[2] === 1'b1 && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        `CHK(cpu_stall_q, 1'b0);
    endtask
    task automatic prog_chk();
        idx = 0;
        for (int k = 0; k < 40; k++) begin
            @(posedge core_clk);
            #1;
            if (flash_prog_q === 1'b1) begin
                `CHK(flash_addr_q, {8'h95, idx[4:0]});
                `CHK(flash_wdata_q, exp_w[idx]);
                idx++;
            end
        end
        `CHK(idx, 32);
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(negedge core_clk);
        reset = 1'b0;
        `CHK(ctrl_q, flash_iap_pkg::CTRL_RESET);
        `CHK(cpu_stall_q, 1'b0);
        for (int r = 0; r < 3; r++) begin
            flash_rdata = rows[r][15:0];
            wr(4'h2, {3'h0, rows[r][28:24]});
            wr(4'h1, rows[r][23:16]);
            wr(4'h0, 8'h32);
            wr(4'h0, 8'h33);
            `CHK(flash_read_q, 1'b1);
            `CHK(flash_addr_q, rows[r][28:16]);
            `CHK({addr_high_q, addr_low_q}, rows[r][28:16]);
            `CHK(cpu_stall_q, 1'b1);
            repeat (3) @(posedge core_clk);
            @(negedge core_clk);
            `CHK(ctrl_q[0], 1'b0);
            `CHK({data0_high_q, data0_low_q}, rows[r][15:0]);
        end
        wr(4'h0, 8'h14);
        `CHK(ctrl_q[2], 1'b0);
        wr(4'h0, 8'h80);
        `CHK(ctrl_q[7], 1'b0);
        wr(4'h0, 8'h68);
        pat(8'h01);
        repeat (30) @(negedge core_clk);
        `CHK(ctrl_q[3], 1'b0);
        `CHK(ctrl_q[7], 1'b0);
        wr(4'h0, 8'h68);
        repeat (30) @(negedge core_clk);
        pat(8'h00);
        repeat (2) @(negedge core_clk);
        `CHK(ctrl_q[7], 1'b0);
        wr(4'h0, 8'h68);
        `CHK(ctrl_q[3], 1'b1);
        pat(8'h00);
        @(negedge core_clk);
        `CHK(ctrl_q[7], 1'b1);
        `CHK({data1_low_q, data2_low_q, data3_low_q}, 24'h000dc3);
        `CHK({data1_high_q, data2_high_q, data3_high_q}, 24'h040940);
        repeat (30) @(negedge core_clk);
        wr(4'h2, 8'h12);
        wr(4'h1, 8'hab);
        wr(4'h0, 8'h94);
        `CHK(cpu_stall_q, 1'b1);
        @(negedge core_clk);
        `CHK(flash_erase_q, 1'b1);
        `CHK(flash_addr_q, 13'h12a0);
        wait_go();
        `CHK(n, PCYC);
        wr(4'h0, 8'h80);
        wr(4'h1, 8'ha0);
        for (int i = 0; i < 34; i++) begin
            w = {8'h5a ^ 8'(i), 8'(i)};
            exp_w[i > 31 ? 31 : i] = w;
            wr(4'h3, w[7:0]);
            wr(4'h4, w[15:8]);
        end
        wr(4'h0, 8'h84);
        prog_chk();
        wait_go();
        wr(4'hb, 8'h01);
        `CHK(buffer_clear_q, 1'b1);
        @(negedge core_clk);
        `CHK(buffer_clear_q, 1'b0);
        for (int i = 0; i < 32; i++) begin
            exp_w[i] = 16'h0000;
        end
        exp_w[0] = 16'hbeef;
        wr(4'h1, 8'ha0);
        wr(4'h3, 8'hef);
        wr(4'h4, 8'hbe);
        wr(4'h0, 8'h84);
        prog_chk();
        wait_go();
        wr(4'h0, 8'h00);
        `CHK(ctrl_q[7], 1'b0);
        wr(4'h0, 8'h04);
        `CHK(ctrl_q[2], 1'b0);
        wrap_up();
    end
endmodule
bind flash_iap_erase_write_read flash_iap_checker #(
    .unlock_cycles(unlock_cycles)) flash_iap_checker_i (
    .core_clk(core_clk), .reset(reset), .reg_wr(reg_wr),
    .reg_sel(reg_sel), .reg_wdata(reg_wdata), .flash_rdata(flash_rdata),
    .ctrl_q(ctrl_q), .data0_low_q(data0_low_q),
    .data0_high_q(data0_high_q), .buffer_clear_q(buffer_clear_q),
    .cpu_stall_q(cpu_stall_q), .flash_erase_q(flash_erase_q),
    .flash_prog_q(flash_prog_q), .flash_read_q(flash_read_q),
    .flash_addr_q(flash_addr_q));
`default_nettype wire
